// [core/vsl_pkg.sv]
// shared constants and types of the single-wire link mode controller
package vsl_pkg;
    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [7:0] ADDR_ROUNDTRIP = 8'h3b;
    localparam logic [7:0] ADDR_CONTROL_ONE = 8'h3c;
    localparam logic [7:0] ADDR_CONTROL_TWO = 8'h3d;
    localparam logic [7:0] ADDR_STATE_VEC = 8'h3e;
    localparam logic [7:0] ADDR_DATA = 8'h3f;
    // ****************************************
    // field positions, masks and reset values
    // ****************************************
    localparam int RECEIVE_POLARITY_BIT = 6;
    localparam int IGNORE_MESSAGE_BIT = 7;
    localparam int WCH_BIT = 0;
    localparam int ANALOG_LOOP_SELECT_BIT = 7;
    localparam int DIGITAL_LOOP_SELECT_BIT = 6;
    localparam int RX4X_BIT = 5;
    localparam int TRANSMIT_END_OF_DATA_BIT = 3;
    localparam logic [7:0] ROUNDTRIP_WMASK = 8'hcf;
    localparam logic [7:0] CONTROL_ONE_WMASK = 8'hf3;
    localparam logic [7:0] RST_ROUNDTRIP = 8'h00;
    localparam logic [7:0] RST_CONTROL_ONE = 8'h00;
    localparam logic [7:0] RST_CONTROL_TWO = 8'h00;
    localparam logic [7:0] RST_DATA = 8'h00;
    // ****************************************
    // timing, _US figures in microseconds, CLK_MHZ in megahertz, SETTLE_CYC in clock cycles
    // ****************************************
    localparam int CLK_MHZ = 100;
    localparam int SHORT_US = 64;
    localparam int LONG_US = 128;
    localparam int SOF_US = 200;
    localparam int SPLIT_US = 96;
    localparam int SOF_MIN_US = 164;
    localparam int EOF_MIN_US = 240;
    localparam int SETTLE_US = 10;
    localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
    // ****************************************
    // filter, check byte, state vector codes
    // ****************************************
    localparam logic [3:0] FILT_TOP = 4'hf;
    localparam logic [7:0] CRC_POLY = 8'h1d;
    localparam logic [7:0] CRC_INIT = 8'hff;
    localparam logic [7:0] CRC_GOOD = 8'hc4;
    localparam int SV_FLAGS = 6;
    localparam logic [3:0] SV_NONE = 4'h0;
    localparam int SV_WAKE = 1;
    localparam int SV_TX_NEED = 2;
    localparam int SV_RX_FULL = 3;
    localparam int SV_EOF = 4;
    localparam int SV_LOST = 5;
    localparam int SV_CRC = 6;
    typedef enum logic [1:0] {VSL_RUN, VSL_WAIT, VSL_STOP} vsl_mode_t;
    typedef enum logic {VSL_TX_IDLE, VSL_TX_SYM} vsl_tx_t;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } vsl_bus_req_t;
endpackage

// [core/vsl_mode_ctrl.sv]
// mode control, filter, symbol codec and register port of the single-wire link
// What this block does
// - in reset all registers and outputs take reset values, inputs ignored
// - any reset source forces run mode at once
// - run mode is held during reset and kept when every reset source is released
// - wait instruction with halt select clear enters wait, clocks running
// - in wait, first passive-to-active edge wakes to run with interrupt
// - in wait, a valid end-of-frame also wakes with interrupt
// - stop instruction, or wait with halt select set, enters stop
// - in stop clocks halt; bus activity wakes to run with interrupt
// - after stop, reception waits for settled clocks and running processor
// - digital loopback joins transmit to receive internally, bus left undriven
// - analog loopback leaves codec alone; on exit wait for idle bus
// - bits coded in variable pulse width at 10.4 kbps
// - quad rate receive mode takes frames at 41.6 kbps
// - receive filter counter saturates 0..15, output flips only at ends
// - transmit check byte: all-ones start, complement appended msb first
// - receive check over data and check byte, remainder not c4 flags error
module vsl_mode_ctrl #(
    parameter int SHORT_CYC = vsl_pkg::SHORT_US * vsl_pkg::CLK_MHZ,
    parameter int LONG_CYC = vsl_pkg::LONG_US * vsl_pkg::CLK_MHZ,
    parameter int SOF_CYC = vsl_pkg::SOF_US * vsl_pkg::CLK_MHZ,
    parameter int SPLIT_CYC = vsl_pkg::SPLIT_US * vsl_pkg::CLK_MHZ,
    parameter int SOF_MIN_CYC = vsl_pkg::SOF_MIN_US * vsl_pkg::CLK_MHZ,
    parameter int EOF_MIN_CYC = vsl_pkg::EOF_MIN_US * vsl_pkg::CLK_MHZ
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // register port
    input wire vsl_pkg::vsl_bus_req_t bus_req,
    output logic [7:0] bus_rdata,
    // processor power handshake
    input wire logic cpu_wait_exec,
    input wire logic cpu_stop_exec,
    input wire logic cpu_running,
    output logic wake_irq,
    output logic clocks_halted,
    output vsl_pkg::vsl_mode_t link_mode,
    // transceiver pins
    input wire logic link_rx_in,
    output logic link_tx_out
);
    logic [7:0] roundtrip, ctl_one, ctl_two, rx_buf, tx_byte, tx_sh, rx_sh, rx_crc, tx_crc;
    logic rx_meta, rx_sync, rx_active_raw, filt_in, filt, filt_q, digital_loop_select;
    logic [3:0] filt_cnt, sv_code, tx_bits;
    logic [15:0] wcnt, sym_cnt;
    logic [1:0] rx_sh_amt;
    logic [2:0] rx_bits;
    logic [11:0] settle;
    logic in_frame, rx_ready, analog_loop_select_q, analog_loop_select_hold, tx_level, tx_full, crc_sent;
    logic edge_evt, sof_evt, bit_evt, bit_val, byte_evt, eof_evt, idle_evt, bus_idle;
    logic sym_end, lost_evt, tx_start, tx_reload, tx_finish, crc_load, tx_bit;
    logic data_wr, data_rd, sv_rd;
    logic [vsl_pkg::SV_FLAGS:1] flag, flag_set, flag_clr;
    vsl_pkg::vsl_tx_t tx_state;

    function automatic logic [7:0] crc_step(input logic [7:0] c, input logic b);
        logic fb;
        fb = c[7] ^ b;
        return {c[6:0], 1'b0} ^ (fb ? vsl_pkg::CRC_POLY : 8'h00);
    endfunction

    // ****************************************
    // pin synchroniser and loopback routing
    // ****************************************
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            rx_meta <= 1'b0;
            rx_sync <= 1'b0;
        end else begin
            rx_meta <= link_rx_in;
            rx_sync <= rx_meta;
        end
    end
    assign rx_active_raw = rx_sync ^ roundtrip[vsl_pkg::RECEIVE_POLARITY_BIT];
    assign digital_loop_select = ctl_two[vsl_pkg::DIGITAL_LOOP_SELECT_BIT];
    assign filt_in = digital_loop_select ? tx_level : rx_active_raw;
    assign link_tx_out = tx_level & ~digital_loop_select;
    assign clocks_halted = (link_mode == vsl_pkg::VSL_STOP);

    // ****************************************
    // receive noise filter
    // ****************************************
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            filt_cnt <= 4'h0;
            filt <= 1'b0;
        end else if (!clocks_halted) begin
            if (filt_in && filt_cnt != vsl_pkg::FILT_TOP) begin
                filt_cnt <= filt_cnt + 4'h1;
            end else if (!filt_in && filt_cnt != 4'h0) begin
                filt_cnt <= filt_cnt - 4'h1;
            end
            if (filt_cnt == vsl_pkg::FILT_TOP) begin
                filt <= 1'b1;
            end else if (filt_cnt == 4'h0) begin
                filt <= 1'b0;
            end
        end
    end

    // ****************************************
    // receive symbol decoder
    // ****************************************
    // quad rate shrinks every receive threshold by four
    assign rx_sh_amt = ctl_two[vsl_pkg::RX4X_BIT] ? 2'd2 : 2'd0;
    assign edge_evt = rx_ready && (filt != filt_q);
    assign sof_evt = edge_evt && filt_q && (wcnt >= (16'(SOF_MIN_CYC) >> rx_sh_amt));
    // a passive period past the start threshold is end-of-data and carries no bit
    assign bit_evt = edge_evt && in_frame && !sof_evt && (wcnt < (16'(SOF_MIN_CYC) >> rx_sh_amt));
    // active short is one, passive long is one
    assign bit_val = filt_q ? (wcnt < (16'(SPLIT_CYC) >> rx_sh_amt)) : (wcnt >= (16'(SPLIT_CYC) >> rx_sh_amt));
    assign byte_evt = bit_evt && (rx_bits == 3'd7);
    assign idle_evt = !filt && (wcnt == (16'(EOF_MIN_CYC) >> rx_sh_amt));
    assign eof_evt = rx_ready && in_frame && idle_evt;
    assign bus_idle = !filt && !in_frame && (wcnt >= (16'(EOF_MIN_CYC) >> rx_sh_amt));

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            filt_q <= 1'b0;
            wcnt <= 16'h0000;
        end else begin
            filt_q <= filt;
            // analog loop exit restarts idle count, else a long-quiet bus never re-arms
            if (filt != filt_q || (analog_loop_select_q && !ctl_two[vsl_pkg::ANALOG_LOOP_SELECT_BIT])) begin
                wcnt <= 16'h0000;
            end else if (wcnt != 16'hffff) begin
                wcnt <= wcnt + 16'h0001;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            in_frame <= 1'b0;
            rx_bits <= 3'd0;
            rx_sh <= 8'h00;
            rx_crc <= vsl_pkg::CRC_INIT;
            rx_buf <= vsl_pkg::RST_DATA;
        end else begin
            if (sof_evt) begin
                in_frame <= 1'b1;
                rx_bits <= 3'd0;
                rx_crc <= vsl_pkg::CRC_INIT;
            end else if (bit_evt) begin
                rx_sh <= {rx_sh[6:0], bit_val};
                // check byte runs through the same divisor
                rx_crc <= crc_step(rx_crc, bit_val);
                rx_bits <= rx_bits + 3'd1;
                if (byte_evt) begin
                    rx_buf <= {rx_sh[6:0], bit_val};
                end
            end else if (eof_evt) begin
                in_frame <= 1'b0;
            end
        end
    end

    // reception held off after stop until settled and processor runs
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            rx_ready <= 1'b1;
            settle <= 12'h000;
        end else if (clocks_halted) begin
            rx_ready <= 1'b0;
            settle <= 12'h000;
        end else if (!rx_ready && cpu_running) begin
            if (settle == 12'(vsl_pkg::SETTLE_CYC - 1)) begin
                rx_ready <= 1'b1;
            end else begin
                settle <= settle + 12'h001;
            end
        end
    end

    // after analog loop exit, a fresh idle period is needed
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            analog_loop_select_q <= 1'b0;
            analog_loop_select_hold <= 1'b0;
        end else begin
            analog_loop_select_q <= ctl_two[vsl_pkg::ANALOG_LOOP_SELECT_BIT];
            if (analog_loop_select_q && !ctl_two[vsl_pkg::ANALOG_LOOP_SELECT_BIT]) begin
                analog_loop_select_hold <= 1'b1;
            end else if (idle_evt) begin
                analog_loop_select_hold <= 1'b0;
            end
        end
    end

    // ****************************************
    // transmit symbol encoder
    // ****************************************
    assign data_wr = bus_req.wr && (bus_req.addr == vsl_pkg::ADDR_DATA);
    assign data_rd = bus_req.rd && (bus_req.addr == vsl_pkg::ADDR_DATA);
    assign sv_rd = bus_req.rd && (bus_req.addr == vsl_pkg::ADDR_STATE_VEC);
    assign sym_end = (tx_state == vsl_pkg::VSL_TX_SYM) && (sym_cnt == 16'h0000);
    // filtered bus level must match what we drive
    assign lost_evt = sym_end && (filt != tx_level);
    assign tx_start = (tx_state == vsl_pkg::VSL_TX_IDLE) && tx_full && bus_idle && !analog_loop_select_hold
        && (link_mode == vsl_pkg::VSL_RUN);
    assign tx_reload = sym_end && !lost_evt && (tx_bits == 4'd0) && tx_full;
    assign crc_load = sym_end && !lost_evt && (tx_bits == 4'd0) && !tx_full && !crc_sent
        && ctl_two[vsl_pkg::TRANSMIT_END_OF_DATA_BIT];
    assign tx_finish = sym_end && !lost_evt && (tx_bits == 4'd0) && !tx_full && !crc_load;
    assign tx_bit = sym_end && !lost_evt && (tx_bits != 4'd0);

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            tx_full <= 1'b0;
            tx_byte <= vsl_pkg::RST_DATA;
        end else if (data_wr) begin
            tx_full <= 1'b1;
            tx_byte <= bus_req.wdata;
        end else if (tx_start || tx_reload) begin
            tx_full <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            tx_state <= vsl_pkg::VSL_TX_IDLE;
            tx_level <= 1'b0;
            sym_cnt <= 16'h0000;
            tx_sh <= 8'h00;
            tx_bits <= 4'd0;
            tx_crc <= vsl_pkg::CRC_INIT;
            crc_sent <= 1'b0;
        end else if (lost_evt || tx_finish) begin
            tx_state <= vsl_pkg::VSL_TX_IDLE;
            tx_level <= 1'b0;
        end else if (tx_start) begin
            tx_state <= vsl_pkg::VSL_TX_SYM;
            tx_level <= 1'b1;
            sym_cnt <= 16'(SOF_CYC - 1);
            tx_sh <= tx_byte;
            tx_bits <= 4'd8;
            tx_crc <= vsl_pkg::CRC_INIT;
            crc_sent <= 1'b0;
        end else if (tx_reload) begin
            tx_sh <= tx_byte;
            tx_bits <= 4'd8;
        end else if (crc_load) begin
            tx_sh <= ~tx_crc;
            tx_bits <= 4'd8;
            crc_sent <= 1'b1;
        end else if (tx_bit) begin
            // level alternates; long when bit differs from new level
            tx_level <= ~tx_level;
            sym_cnt <= (tx_sh[7] ^ ~tx_level) ? 16'(LONG_CYC - 1) : 16'(SHORT_CYC - 1);
            tx_sh <= {tx_sh[6:0], 1'b0};
            tx_bits <= tx_bits - 4'd1;
            if (!crc_sent) begin
                tx_crc <= crc_step(tx_crc, tx_sh[7]);
            end
        end else if (sym_cnt != 16'h0000) begin
            sym_cnt <= sym_cnt - 16'h0001;
        end
    end

    // ****************************************
    // operating mode
    // ****************************************
    // synchronous reset pulls back to reset state from any mode
    // a frame still in flight is not aborted on leaving run mode
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            link_mode <= vsl_pkg::VSL_RUN;
            wake_irq <= 1'b0;
        end else begin
            wake_irq <= 1'b0;
            case (link_mode)
                vsl_pkg::VSL_RUN: begin
                    if (cpu_stop_exec || (cpu_wait_exec && ctl_one[vsl_pkg::WCH_BIT])) begin
                        link_mode <= vsl_pkg::VSL_STOP;
                    end else if (cpu_wait_exec) begin
                        link_mode <= vsl_pkg::VSL_WAIT;
                    end
                end
                vsl_pkg::VSL_WAIT: begin
                    if ((filt && !filt_q) || eof_evt) begin
                        link_mode <= vsl_pkg::VSL_RUN;
                        wake_irq <= 1'b1;
                    end
                end
                vsl_pkg::VSL_STOP: begin
                    // raw activity wakes since the filter is frozen
                    if (rx_active_raw) begin
                        link_mode <= vsl_pkg::VSL_RUN;
                        wake_irq <= 1'b1;
                    end
                end
                default: link_mode <= vsl_pkg::VSL_RUN;
            endcase
        end
    end

    // ****************************************
    // status flags and state vector
    // ****************************************
    always_comb begin
        flag_set = '0;
        flag_set[vsl_pkg::SV_WAKE] = wake_irq;
        flag_set[vsl_pkg::SV_TX_NEED] = tx_start || tx_reload;
        flag_set[vsl_pkg::SV_RX_FULL] = byte_evt && !ctl_one[vsl_pkg::IGNORE_MESSAGE_BIT];
        flag_set[vsl_pkg::SV_EOF] = eof_evt;
        flag_set[vsl_pkg::SV_LOST] = lost_evt;
        // bad remainder at end of frame
        flag_set[vsl_pkg::SV_CRC] = eof_evt && (rx_crc != vsl_pkg::CRC_GOOD);
    end

    // reading the vector clears only the cause it showed (rx full and tx need clear on data access instead), so others are not lost
    always_comb begin
        flag_clr = '0;
        for (int k = 1; k <= vsl_pkg::SV_FLAGS; k++) begin
            flag_clr[k] = sv_rd && (sv_code == 4'(k));
        end
        flag_clr[vsl_pkg::SV_RX_FULL] = data_rd;
        flag_clr[vsl_pkg::SV_TX_NEED] = data_wr;
    end

    for (genvar k = 1; k <= vsl_pkg::SV_FLAGS; k++) begin : g_flag
        always_ff @(posedge mclk) begin
            if (!rst_b) begin
                flag[k] <= 1'b0;
            end else begin
                flag[k] <= flag_set[k] | (flag[k] & ~flag_clr[k]);
            end
        end
    end

    // highest pending cause wins the code
    always_comb begin
        sv_code = vsl_pkg::SV_NONE;
        for (int k = 1; k <= vsl_pkg::SV_FLAGS; k++) begin
            if (flag[k]) begin
                sv_code = 4'(k);
            end
        end
    end

    // ****************************************
    // register port
    // ****************************************
    // registers return to reset values
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            roundtrip <= vsl_pkg::RST_ROUNDTRIP;
            ctl_one <= vsl_pkg::RST_CONTROL_ONE;
            ctl_two <= vsl_pkg::RST_CONTROL_TWO;
        end else begin
            if (sof_evt) begin
                ctl_one[vsl_pkg::IGNORE_MESSAGE_BIT] <= 1'b0;
            end
            if (lost_evt || tx_finish) begin
                ctl_two[vsl_pkg::TRANSMIT_END_OF_DATA_BIT] <= 1'b0;
            end
            if (bus_req.wr) begin
                case (bus_req.addr)
                    vsl_pkg::ADDR_ROUNDTRIP: roundtrip <= bus_req.wdata & vsl_pkg::ROUNDTRIP_WMASK;
                    vsl_pkg::ADDR_CONTROL_ONE: ctl_one <= bus_req.wdata & vsl_pkg::CONTROL_ONE_WMASK;
                    vsl_pkg::ADDR_CONTROL_TWO: ctl_two <= bus_req.wdata;
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            bus_rdata <= 8'h00;
        end else if (bus_req.rd) begin
            case (bus_req.addr)
                vsl_pkg::ADDR_ROUNDTRIP: bus_rdata <= roundtrip;
                vsl_pkg::ADDR_CONTROL_ONE: bus_rdata <= ctl_one;
                vsl_pkg::ADDR_CONTROL_TWO: bus_rdata <= ctl_two;
                vsl_pkg::ADDR_STATE_VEC: bus_rdata <= {2'b00, sv_code, 2'b00};
                vsl_pkg::ADDR_DATA: bus_rdata <= rx_buf;
                default: bus_rdata <= 8'h00;
            endcase
        end else begin
            bus_rdata <= 8'h00;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    sequence woke_s;
        link_mode == vsl_pkg::VSL_RUN ##0 wake_irq;
    endsequence

    release_run_a: assert property ($rose(rst_b) |-> link_mode == vsl_pkg::VSL_RUN && !link_tx_out)
        else $error("not in run mode after reset release");
    wait_entry_a: assert property (link_mode == vsl_pkg::VSL_RUN && cpu_wait_exec && !cpu_stop_exec
        && !ctl_one[vsl_pkg::WCH_BIT] |=> link_mode == vsl_pkg::VSL_WAIT && !clocks_halted)
        else $error("wait entry missed");
    stop_entry_a: assert property (link_mode == vsl_pkg::VSL_RUN && (cpu_stop_exec
        || (cpu_wait_exec && ctl_one[vsl_pkg::WCH_BIT])) |=> clocks_halted)
        else $error("stop entry missed");
    wait_wake_a: assert property (link_mode == vsl_pkg::VSL_WAIT && filt && !filt_q |=> woke_s)
        else $error("bus edge did not wake");
    eof_wake_a: assert property (link_mode == vsl_pkg::VSL_WAIT && eof_evt |=> woke_s)
        else $error("end of frame did not wake");
    stop_wake_a: assert property (clocks_halted && rx_active_raw |=> woke_s ##1 !wake_irq)
        else $error("stop wake wrong");
    stop_blind_a: assert property (clocks_halted |=> !rx_ready)
        else $error("receiver live after stop");
    digital_loop_select_quiet_a: assert property (digital_loop_select |-> !link_tx_out)
        else $error("bus driven in digital loop");
    filter_end_a: assert property (!clocks_halted && filt_cnt == vsl_pkg::FILT_TOP |=> filt)
        else $error("filter did not settle high");
    crc_flag_a: assert property (eof_evt && rx_crc != vsl_pkg::CRC_GOOD |=> flag[vsl_pkg::SV_CRC])
        else $error("check error not flagged");
    lost_stop_a: assert property (lost_evt |=> !link_tx_out && tx_state == vsl_pkg::VSL_TX_IDLE
        && flag[vsl_pkg::SV_LOST])
        else $error("loss did not stop sending");
endmodule

// [tb/vsl_xcvr_model.sv]
// stand-in for the off-chip transceiver of the single-wire link
module vsl_xcvr_model (
    // clock
    input wire logic mclk,
    // digital side
    input wire logic tx_in,
    output logic rx_out,
    // other nodes on the wire
    input wire logic other_drive
);
    timeunit 1ns;
    timeprecision 1ps;
    // wired-or bus, one cycle of lag stands in for the analog path
    always_ff @(posedge mclk) begin
        rx_out <= tx_in | other_drive;
    end
endmodule

// [tb/vsl_serial_link_mode_control_bench.sv]
// register, power mode and loopback tests of the link mode controller
module vsl_serial_link_mode_control_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, rst_b, w_ex, s_ex, run, ext, rx, tx, irq, halted;
    vsl_pkg::vsl_bus_req_t req;
    logic [7:0] rdata;
    vsl_pkg::vsl_mode_t mode;
    int miscompares, n_compared, n;
    // ****************************************
    // design and far side
    // ****************************************
    // split threshold stays at its default: looped frames use short symbols only, which decode alike
    vsl_mode_ctrl #(.SHORT_CYC(64), .LONG_CYC(128), .SOF_CYC(200), .SOF_MIN_CYC(164),
        .EOF_MIN_CYC(240)) dut_u (.mclk(mclk), .rst_b(rst_b), .bus_req(req), .bus_rdata(rdata),
        .cpu_wait_exec(w_ex), .cpu_stop_exec(s_ex), .cpu_running(run), .wake_irq(irq),
        .clocks_halted(halted), .link_mode(mode), .link_rx_in(rx), .link_tx_out(tx));
    vsl_xcvr_model xcvr_u (.mclk(mclk), .tx_in(tx), .rx_out(rx), .other_drive(ext));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // ****************************************
    // access and check tasks
    // ****************************************
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk) req <= '{a, d, 1'b1, 1'b0};
        @(posedge mclk) req.wr <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk) req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge mclk) req.rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask
    task automatic give_verdict;
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge mclk);
        miscompares++;
        give_verdict;
    end
    // ****************************************
    // test sequence
    // ****************************************
    initial begin
        rst_b = 1'b0; req = '0; w_ex = 1'b0; s_ex = 1'b0; run = 1'b1; ext = 1'b0;
        miscompares = 0; n_compared = 0;
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        // reset values, unmapped offset included
        for (int a = 8'h3b; a <= 8'h40; a++) rd(8'(a), 8'h00);
        chk({6'h00, mode}, 8'h00);
        $display("reset values done");
        wr(8'h3b, 8'hbf);
        rd(8'h3b, 8'h8f);
        wr(8'h3c, 8'hbe);
        rd(8'h3c, 8'hb2);
        wr(8'h3d, 8'hff);
        rd(8'h3d, 8'hff);
        wr(8'h3b, 8'h00);
        wr(8'h3d, 8'h00);
        $display("register access done");
        // no frame is in flight whenever the processor sleeps
        // kind 0 wait, kind 1 wait with halt select, kind 2 stop
        for (int k = 0; k < 3; k++) begin
            wr(8'h3c, (k == 1) ? 8'h01 : 8'h00);
            @(posedge mclk) begin
                if (k == 2) s_ex <= 1'b1;
                else w_ex <= 1'b1;
            end
            @(posedge mclk) {w_ex, s_ex} <= 2'b00;
            #1 chk({6'h00, mode}, (k == 0) ? 8'h01 : 8'h02);
            chk({7'h00, halted}, (k == 0) ? 8'h00 : 8'h01);
            if (k == 2) begin
                // a reset mid-stop must return to run at once
                @(posedge mclk) rst_b <= 1'b0;
                repeat (2) @(posedge mclk);
                #1 chk({5'h00, halted, mode}, 8'h00);
                @(posedge mclk) rst_b <= 1'b1;
                rd(8'h3c, 8'h00);
            end else begin
                @(posedge mclk) ext <= 1'b1;
                n = 0;
                while (irq !== 1'b1 && n < 100) begin
                    @(posedge mclk);
                    #1 n++;
                end
                chk({5'h00, irq, mode}, 8'h04);
                @(posedge mclk) ext <= 1'b0;
                if (k == 0) rd(8'h3e, 8'h04);
            end
        end
        wr(8'h3c, 8'h00);
        $display("power modes done");
        repeat (300) @(posedge mclk);
        // looped frame must never reach the pin
        wr(8'h3d, 8'h40);
        wr(8'h3f, 8'h55);
        n = 0;
        repeat (600) begin
            @(posedge mclk);
            #1 if (tx !== 1'b0) n++;
        end
        chk(8'(n), 8'h00);
        repeat (3000) @(posedge mclk);
        // the looped byte came back; a lone byte without its check byte must fail the check
        rd(8'h3f, 8'h55);
        rd(8'h3e, 8'h18);
        rd(8'h3e, 8'h10);
        wr(8'h3d, 8'h00);
        $display("digital loopback done");
        repeat (300) @(posedge mclk);
        wr(8'h3f, 8'h5a);
        n = 0;
        while (tx !== 1'b1 && n < 600) begin
            @(posedge mclk);
            #1 n++;
        end
        n = 0;
        while (tx === 1'b1 && n < 400) begin
            n++;
            @(posedge mclk);
            #1;
        end
        chk(8'(n), 8'hc8);
        repeat (3000) @(posedge mclk);
        $display("start of frame done");
        give_verdict;
    end
endmodule
